// >>> design/cmr_cfg.svh
// constants for the mode, address wrap and interrupt control block
// assumes inclusion by bare name from design files
`ifndef CMR_CFG_SVH
`define CMR_CFG_SVH
`define CMR_STACK_EMU_PAGE  8'h01
`define CMR_ZERO_BYTE       8'h00
`define CMR_BANK_ZERO       8'h00
`define CMR_PAGE_ZERO       8'h00
`define CMR_ABT_CLR_CYC     3'd2
`define CMR_RTI_MOD_CYC     3'd3
`define CMR_INT_BANK_CYC    3'd2
`define CMR_SEQ_LAST        3'd7
`endif

// >>> design/cmr_pkg.sv
// types for the mode, address wrap and interrupt control block
// assumes no other package
package cmr_pkg;
    typedef enum logic [2:0] {
        CMR_RUN,
        CMR_INT_SEQ,
        CMR_WAIT,
        CMR_WAIT_ABORTED,
        CMR_STOPPED
    } cmr_state_t;

    typedef enum logic [1:0] {
        CMR_SRC_NONE,
        CMR_SRC_ABORT,
        CMR_SRC_NMI,
        CMR_SRC_IRQ
    } cmr_src_t;

    typedef enum logic [2:0] {
        CMR_AM_STACK,
        CMR_AM_STACK_LONG,
        CMR_AM_DIRECT,
        CMR_AM_DIRECT_LONG,
        CMR_AM_ABS_INDEXED,
        CMR_AM_PTR_DIRECT_BANK,
        CMR_AM_PTR_PROGRAM_BANK
    } cmr_amode_t;

    typedef struct packed {
        cmr_state_t  state;
        cmr_src_t    src;
        logic [2:0]  seqCycle;
        logic        abortLatch;
        logic        emulation;
        logic        accWidth;
        logic        idxWidth;
        logic        decimalFlag;
        logic        irqDisable;
        logic [7:0]  programBank;
        logic [7:0]  dataBank;
        logic [7:0]  stackHigh;
        logic [7:0]  xHigh;
        logic [7:0]  yHigh;
        logic        widthInvalid;
        logic        pushBank;
        logic [23:0] effAddr;
        logic        addrValid;
        logic        fixCycle;
        logic        vecTaken;
        logic        resumeNext;
        logic        writeHeld;
        logic [2:0]  rstSync;
        logic [2:0]  abtSync;
        logic [2:0]  nmiSync;
        logic [2:0]  irqSync;
        logic        nmiPrev;
    } cmr_state_s_t;
endpackage : cmr_pkg

// >>> design/cmr_mode_ctrl.sv
// mode, address wrap and interrupt control of a 16-bit processor core
// assumes pin inputs asynchronous to clk; opcode strobes from the decoder on clk
//Function
//- stack stays in bank zero native, page one emulation; long stack ops may step past
//- direct addresses bank zero native, direct register page emulation; long indirect runs into stack page
//- emulation with zero direct low byte wraps in page; long indirect from base fe or ff carries up
//- emulation with nonzero direct low byte never wraps in page
//- absolute indexed carries into bank byte
//- abort latch cleared in sequence cycle two; abort from cycle two on in an abort sequence restarts it at cycle zero
//- late abort still changes status and clears banks after cycle two
//- address valid whenever valid outputs high; fix cycles hold valid data low
//- low byte fix cycle optional for 8-bit reads, forced otherwise
//- ready low holds data bus in transfer state
//- width output invalid the cycle after flag change ops
//- emulation keeps width bits at one against flag ops
//- indirect jumps use direct bank, indexed tables use program bank
//- to emulation sets widths, stack high 01, index highs 00
//- native interrupt flags program bank push and clears it in the same cycle; emulation clears both, no push
//- every interrupt clears decimal flag
//- wait op drives ready low; nmi irq reset end it; abort stops without restart
//- masked irq in wait resumes next instruction without handler
//- priority reset, abort, nmi, irq
//- stop op holds clock high until reset falls
//- ready low in write cycle pulls ready line low the next cycle
//
`timescale 1ns/1ns
`default_nettype none
`include "cmr_cfg.svh"
module cmr_mode_ctrl (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        reset_in_n,
    input  wire logic        abort_in_n,
    input  wire logic        nonmaskable_irq_n,
    input  wire logic        maskable_irq_n,
    input  wire logic        readyIn,
    input  wire logic        swBreakStart,
    input  wire logic        trapStart,
    input  wire logic        intReturnStep,
    input  wire logic        rmwModifyDone,
    input  wire logic        haltUntilIrqOp,
    input  wire logic        stopClockOp,
    input  wire logic        clearFlagsOp,
    input  wire logic        setFlagsOp,
    input  wire logic        pullFlagsOp,
    input  wire logic [7:0]  flagsOperand,
    input  wire logic        exchangeEmu,
    input  wire logic        newEmulation,
    input  wire logic        setIrqDisable,
    input  wire logic        clrIrqDisable,
    input  wire logic        addrReq,
    input  wire logic [2:0]  addrMode,
    input  wire logic [15:0] baseAddr,
    input  wire logic [15:0] addrOffset,
    input  wire logic [15:0] directReg,
    input  wire logic        isWrite,
    input  wire logic        isStore,
    input  wire logic        isRmw,
    input  wire logic        isLongStackOp,
    output logic             emulationOut,
    output logic [1:0]       width_status_out,
    output logic             widthValid,
    output logic             decimalOut,
    output logic [7:0]       program_bank_reg,
    output logic [7:0]       data_bank_reg,
    output logic [7:0]       stackHighOut,
    output logic [7:0]       xHighOut,
    output logic [7:0]       yHighOut,
    output logic             pushProgramBank,
    output logic [23:0]      effAddrOut,
    output logic             valid_data_addr,
    output logic             valid_program_addr,
    output logic             fixCycleOut,
    output logic             ready_line,
    output logic             dataBusTransfer,
    output logic             bankMuxEnable,
    output logic             phase_two_clock_gate,
    output logic             vectorTaken,
    output logic [1:0]       vectorSource,
    output logic             resumeAfterWait,
    output logic             abortPending,
    output logic             interruptActive
);
    cmr_pkg::cmr_state_s_t cur;
    cmr_pkg::cmr_state_s_t next_cur;

    logic rstLvl;
    logic abtLvl;
    logic nmiLvl;
    logic irqLvl;
    logic abtFall;
    logic nmiFall;
    logic [16:0] sum17;
    logic [23:0] sum24;
    logic [7:0]  lowSum;
    logic [15:0] dirSum;

    // three stage sync filters
    assign rstLvl  = (cur.rstSync[2] == cur.rstSync[1]) ? ~cur.rstSync[2] : 1'b0;
    assign abtLvl  = (cur.abtSync[2] == cur.abtSync[1]) ? ~cur.abtSync[2] : 1'b0;
    assign nmiLvl  = (cur.nmiSync[2] == cur.nmiSync[1]) ? ~cur.nmiSync[2] : 1'b0;
    assign irqLvl  = (cur.irqSync[2] == cur.irqSync[1]) ? ~cur.irqSync[2] : 1'b0;
    assign abtFall = abtLvl & ~cur.abortLatch;
    assign nmiFall = nmiLvl & ~cur.nmiPrev;

    assign sum17  = {1'b0, baseAddr} + {1'b0, addrOffset};
    assign sum24  = {cur.dataBank, baseAddr} + {8'h00, addrOffset};
    assign lowSum = baseAddr[7:0] + addrOffset[7:0];
    assign dirSum = directReg + baseAddr;

    always_comb begin
        next_cur = cur;
        next_cur.rstSync = {cur.rstSync[1:0], reset_in_n};
        next_cur.abtSync = {cur.abtSync[1:0], abort_in_n};
        next_cur.nmiSync = {cur.nmiSync[1:0], nonmaskable_irq_n};
        next_cur.irqSync = {cur.irqSync[1:0], maskable_irq_n};
        next_cur.nmiPrev = nmiLvl;
        next_cur.vecTaken = 1'b0;
        next_cur.resumeNext = 1'b0;
        next_cur.pushBank = 1'b0;
        next_cur.widthInvalid = 1'b0;
        if (abtFall) begin
            next_cur.abortLatch = 1'b1;
        end
        if (setIrqDisable) begin
            next_cur.irqDisable = 1'b1;
        end else if (clrIrqDisable) begin
            next_cur.irqDisable = 1'b0;
        end
        if (clearFlagsOp || setFlagsOp || pullFlagsOp) begin
            next_cur.widthInvalid = 1'b1;
        end
        if (cur.emulation) begin
            next_cur.accWidth = 1'b1;
            next_cur.idxWidth = 1'b1;
        end else if (clearFlagsOp) begin
            next_cur.accWidth = cur.accWidth & ~flagsOperand[5];
            next_cur.idxWidth = cur.idxWidth & ~flagsOperand[4];
        end else if (setFlagsOp) begin
            next_cur.accWidth = cur.accWidth | flagsOperand[5];
            next_cur.idxWidth = cur.idxWidth | flagsOperand[4];
        end else if (pullFlagsOp) begin
            next_cur.accWidth = flagsOperand[5];
            next_cur.idxWidth = flagsOperand[4];
        end
        if (clearFlagsOp) begin
            next_cur.decimalFlag = cur.decimalFlag & ~flagsOperand[3];
        end else if (setFlagsOp) begin
            next_cur.decimalFlag = cur.decimalFlag | flagsOperand[3];
        end else if (pullFlagsOp) begin
            next_cur.decimalFlag = flagsOperand[3];
        end
        if (exchangeEmu) begin
            next_cur.emulation = newEmulation;
            if (newEmulation && !cur.emulation) begin
                next_cur.accWidth = 1'b1;
                next_cur.idxWidth = 1'b1;
                next_cur.stackHigh = `CMR_STACK_EMU_PAGE;
                next_cur.xHigh = `CMR_ZERO_BYTE;
                next_cur.yHigh = `CMR_ZERO_BYTE;
            end
        end
        // address generation
        next_cur.addrValid = 1'b0;
        next_cur.fixCycle = 1'b0;
        if (addrReq) begin
            next_cur.addrValid = 1'b1;
            case (addrMode)
                3'd0: begin
                    if (cur.emulation && !isLongStackOp) begin
                        next_cur.effAddr = {`CMR_BANK_ZERO, `CMR_STACK_EMU_PAGE, sum17[7:0]};
                    end else begin
                        next_cur.effAddr = {`CMR_BANK_ZERO, sum17[15:0]};
                    end
                end
                3'd1: next_cur.effAddr = {`CMR_BANK_ZERO, sum17[15:0]};
                3'd2, 3'd3: begin
                    if (!cur.emulation || directReg[7:0] != 8'h00 ||
                        (addrMode == 3'd3 && baseAddr[7:1] == 7'h7f)) begin
                        next_cur.effAddr = {`CMR_BANK_ZERO, dirSum + addrOffset};
                    end else begin
                        next_cur.effAddr = {`CMR_BANK_ZERO, directReg[15:8], lowSum};
                    end
                end
                3'd4: begin
                    next_cur.effAddr = sum24;
                    next_cur.fixCycle = isStore | isRmw | ~cur.idxWidth | sum17[8] ^ baseAddr[8] ^ addrOffset[8];
                end
                3'd5: next_cur.effAddr = {`CMR_BANK_ZERO, baseAddr};
                3'd6: next_cur.effAddr = {cur.programBank, sum17[15:0]};
                default: next_cur.effAddr = cur.effAddr;
            endcase
        end
        case (cur.state)
            cmr_pkg::CMR_RUN: begin
                if (rstLvl) begin
                    next_cur.state = cmr_pkg::CMR_RUN;
                end else if (cur.abortLatch || abtFall) begin
                    next_cur.state = cmr_pkg::CMR_INT_SEQ;
                    next_cur.src = cmr_pkg::CMR_SRC_ABORT;
                    next_cur.seqCycle = 3'd0;
                end else if (nmiFall) begin
                    next_cur.state = cmr_pkg::CMR_INT_SEQ;
                    next_cur.src = cmr_pkg::CMR_SRC_NMI;
                    next_cur.seqCycle = 3'd0;
                end else if (irqLvl && !cur.irqDisable) begin
                    next_cur.state = cmr_pkg::CMR_INT_SEQ;
                    next_cur.src = cmr_pkg::CMR_SRC_IRQ;
                    next_cur.seqCycle = 3'd0;
                end else if (swBreakStart || trapStart) begin
                    next_cur.state = cmr_pkg::CMR_INT_SEQ;
                    next_cur.src = cmr_pkg::CMR_SRC_NONE;
                    next_cur.seqCycle = 3'd0;
                end else if (haltUntilIrqOp) begin
                    next_cur.state = cmr_pkg::CMR_WAIT;
                end else if (stopClockOp) begin
                    next_cur.state = cmr_pkg::CMR_STOPPED;
                end
                if (cur.abortLatch && (rmwModifyDone || intReturnStep)) begin
                    next_cur.decimalFlag = cur.decimalFlag;
                end
            end
            cmr_pkg::CMR_INT_SEQ: begin
                next_cur.seqCycle = cur.seqCycle + 3'd1;
                if (cur.src == cmr_pkg::CMR_SRC_ABORT && cur.seqCycle == `CMR_ABT_CLR_CYC - 3'd1) begin
                    next_cur.abortLatch = abtLvl;
                end
                if (cur.src == cmr_pkg::CMR_SRC_ABORT && abtFall && cur.seqCycle != 3'd0) begin
                    next_cur.seqCycle = 3'd0;
                end
                if (cur.seqCycle == `CMR_INT_BANK_CYC) begin
                    next_cur.pushBank = ~cur.emulation;
                    next_cur.programBank = `CMR_BANK_ZERO;
                    if (cur.emulation) begin
                        next_cur.dataBank = `CMR_BANK_ZERO;
                    end
                    next_cur.decimalFlag = 1'b0;
                    next_cur.irqDisable = 1'b1;
                end
                if (cur.seqCycle == `CMR_SEQ_LAST) begin
                    next_cur.state = cmr_pkg::CMR_RUN;
                    next_cur.vecTaken = 1'b1;
                end
            end
            cmr_pkg::CMR_WAIT, cmr_pkg::CMR_WAIT_ABORTED: begin
                if (rstLvl) begin
                    next_cur.state = cmr_pkg::CMR_RUN;
                end else if (cur.abortLatch && cur.state == cmr_pkg::CMR_WAIT) begin
                    next_cur.state = cmr_pkg::CMR_WAIT_ABORTED;
                    next_cur.abortLatch = abtLvl;
                end else if (nmiFall || (irqLvl && !cur.irqDisable)) begin
                    next_cur.state = cmr_pkg::CMR_INT_SEQ;
                    next_cur.src = nmiFall ? cmr_pkg::CMR_SRC_NMI : cmr_pkg::CMR_SRC_IRQ;
                    next_cur.seqCycle = 3'd0;
                end else if (irqLvl) begin
                    next_cur.state = cmr_pkg::CMR_RUN;
                    next_cur.resumeNext = cur.state == cmr_pkg::CMR_WAIT;
                end
            end
            cmr_pkg::CMR_STOPPED: begin
                if (rstLvl) begin
                    next_cur.state = cmr_pkg::CMR_RUN;
                end
            end
            default: next_cur.state = cmr_pkg::CMR_RUN;
        endcase
        next_cur.writeHeld = isWrite & ~readyIn;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
            cur.state <= cmr_pkg::CMR_RUN;
            cur.emulation <= 1'b1;
            cur.accWidth <= 1'b1;
            cur.idxWidth <= 1'b1;
            cur.irqDisable <= 1'b1;
            cur.stackHigh <= `CMR_STACK_EMU_PAGE;
            cur.rstSync <= 3'b111;
            cur.abtSync <= 3'b111;
            cur.nmiSync <= 3'b111;
            cur.irqSync <= 3'b111;
        end else begin
            cur <= next_cur;
        end
    end

    assign emulationOut = cur.emulation;
    assign width_status_out = {cur.accWidth, cur.idxWidth};
    assign widthValid = ~cur.widthInvalid;
    assign decimalOut = cur.decimalFlag;
    assign program_bank_reg = cur.programBank;
    assign data_bank_reg = cur.dataBank;
    assign stackHighOut = cur.stackHigh;
    assign xHighOut = cur.xHigh;
    assign yHighOut = cur.yHigh;
    assign pushProgramBank = cur.pushBank;
    assign effAddrOut = cur.effAddr;
    assign valid_data_addr = cur.addrValid & ~cur.fixCycle;
    assign valid_program_addr = 1'b0;
    assign fixCycleOut = cur.fixCycle;
    assign ready_line = ~(cur.state == cmr_pkg::CMR_WAIT || cur.state == cmr_pkg::CMR_WAIT_ABORTED) & ~cur.writeHeld;
    assign dataBusTransfer = ~readyIn | cur.state == cmr_pkg::CMR_STOPPED | cur.writeHeld;
    assign bankMuxEnable = ~cur.emulation & cur.state != cmr_pkg::CMR_STOPPED;
    assign phase_two_clock_gate = cur.state == cmr_pkg::CMR_STOPPED;
    assign vectorTaken = cur.vecTaken;
    assign vectorSource = cur.src;
    assign resumeAfterWait = cur.resumeNext;
    assign abortPending = cur.abortLatch;
    assign interruptActive = cur.state == cmr_pkg::CMR_INT_SEQ;
endmodule : cmr_mode_ctrl
`default_nettype wire

// >>> test/cmr_mode_ctrl_props.sv
// assertions for the mode, address wrap and interrupt control block
// assumes binding onto cmr_mode_ctrl, single clk domain, sync reset rst
`timescale 1ns/1ns
`default_nettype none
module cmr_mode_ctrl_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        readyIn,
    input wire logic        clearFlagsOp,
    input wire logic        haltUntilIrqOp,
    input wire logic        addrReq,
    input wire logic [2:0]  addrMode,
    input wire logic [15:0] baseAddr,
    input wire logic [15:0] addrOffset,
    input wire logic        isStore,
    input wire logic        isLongStackOp,
    input wire logic        emulationOut,
    input wire logic [1:0]  width_status_out,
    input wire logic        widthValid,
    input wire logic        decimalOut,
    input wire logic [7:0]  program_bank_reg,
    input wire logic [7:0]  data_bank_reg,
    input wire logic [7:0]  stackHighOut,
    input wire logic [23:0] effAddrOut,
    input wire logic        fixCycleOut,
    input wire logic        ready_line,
    input wire logic        dataBusTransfer,
    input wire logic        vectorTaken,
    input wire logic        interruptActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_int_start; $rose(interruptActive); endsequence
    sequence s_int_vector; ##[1:12] vectorTaken; endsequence
    property p_emu_width; emulationOut |-> width_status_out == 2'b11; endproperty
    property p_emu_stack; emulationOut |-> stackHighOut == 8'h01; endproperty
    property p_stack_page;
        addrReq && addrMode == 3'h0 && emulationOut && !isLongStackOp |=> effAddrOut[23:8] == 16'h0001;
    endproperty
    property p_abs_carry;
        addrReq && addrMode == 3'h4 |=> effAddrOut == $past({data_bank_reg, baseAddr}) + {8'h00, $past(addrOffset)};
    endproperty
    property p_fix_store; addrReq && isStore && addrMode == 3'h4 |=> fixCycleOut; endproperty
    property p_width_invalid; clearFlagsOp && !emulationOut |=> !widthValid; endproperty
    property p_int_seq; s_int_start |-> s_int_vector; endproperty
    property p_int_clear;
        vectorTaken |-> !decimalOut && program_bank_reg == 8'h00 && (!emulationOut || data_bank_reg == 8'h00);
    endproperty
    property p_wait_ready; haltUntilIrqOp |=> !ready_line; endproperty
    property p_ready_hold; !readyIn |-> dataBusTransfer; endproperty
    a_emu_width: assert property (p_emu_width) else $error("width bits not one in emulation");
    a_emu_stack: assert property (p_emu_stack) else $error("stack high not 01 in emulation");
    a_stack_page: assert property (p_stack_page) else $error("stack address left page one");
    a_abs_carry: assert property (p_abs_carry) else $error("indexed address lost bank carry");
    a_fix_store: assert property (p_fix_store) else $error("store without fix cycle");
    a_width_invalid: assert property (p_width_invalid) else $error("width stayed valid after flag op");
    a_int_seq: assert property (p_int_seq) else $error("interrupt sequence never vectored");
    a_int_clear: assert property (p_int_clear) else $error("interrupt left bank or decimal set");
    a_wait_ready: assert property (p_wait_ready) else $error("wait did not pull ready low");
    a_ready_hold: assert property (p_ready_hold) else $error("bus left transfer state");
endmodule : cmr_mode_ctrl_props
bind cmr_mode_ctrl cmr_mode_ctrl_props u_props (.*);
`default_nettype wire

// >>> test/cmr_mem_model.sv
// external memory system and bank latch model
// assumes device outputs settle on the clk rising edge
`timescale 1ns/1ns
`default_nettype none
module cmr_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        stallReq,
    input  wire logic        valid_data_addr,
    input  wire logic        valid_program_addr,
    input  wire logic        bankMuxEnable,
    input  wire logic [23:0] effAddrOut,
    output logic             readyIn,
    output logic [23:0]      lastAddr,
    output logic [7:0]       bankLatch
);
    logic [2:0] stallCnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            stallCnt <= 3'h0;
        end else begin
            stallCnt <= stallReq ? 3'h4 : stallCnt - {2'h0, stallCnt != 3'h0};
        end
        if (valid_data_addr || valid_program_addr) begin
            lastAddr <= effAddrOut;
        end
        if (bankMuxEnable) begin
            bankLatch <= effAddrOut[23:16];
        end
    end
    assign readyIn = (stallCnt == 3'h0);
endmodule : cmr_mem_model
`default_nettype wire

// >>> test/test_cmr_mode_ctrl.sv
// self-checking bench for the mode, address wrap and interrupt control block
// assumes the memory model drives readyIn; pins idle high
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errTotal++; $display("mismatch %s exp %h got %h", nm, e, g); end end
`define TMO(c) if (!(c)) begin errTotal++; finishTest(); end
`define WAITFOR(c) begin for (w = 0; w < 40 && !(c); w++) begin @(posedge clk); #1; end `TMO(c) end
`define PULSE(s) begin s <= 1'b1; @(posedge clk); s <= 1'b0; #1; end
module test_cmr_mode_ctrl;
    logic clk = 1'b0, rst = 1'b1, resN = 1'b1, abtN = 1'b1, nmiN = 1'b1, irqN = 1'b1, stallReq = 1'b0;
    logic swBreakStart = 1'b0, trapStart = 1'b0, intReturnStep = 1'b0, rmwModifyDone = 1'b0, haltUntilIrqOp = 1'b0;
    logic stopClockOp = 1'b0, clearFlagsOp = 1'b0, setFlagsOp = 1'b0, pullFlagsOp = 1'b0, exchangeEmu = 1'b0;
    logic newEmulation = 1'b1, setIrqDisable = 1'b0, clrIrqDisable = 1'b0, addrReq = 1'b0, isWrite = 1'b0;
    logic isStore = 1'b0, isRmw = 1'b0, isLongStackOp = 1'b0;
    logic [7:0] flagsOperand = 8'h00;
    logic [2:0] addrMode = 3'h0;
    logic [15:0] baseAddr = 16'h0000, addrOffset = 16'h0000, directReg = 16'h0000;
    wire logic readyIn, emulationOut, widthValid, decimalOut, pushProgramBank, valid_data_addr, valid_program_addr;
    wire logic fixCycleOut, ready_line, dataBusTransfer, bankMuxEnable, phase_two_clock_gate, vectorTaken;
    wire logic resumeAfterWait, abortPending, interruptActive;
    wire logic [1:0] width_status_out, vectorSource;
    wire logic [7:0] program_bank_reg, data_bank_reg, stackHighOut, xHighOut, yHighOut;
    wire logic [23:0] effAddrOut;
    int errTotal = 0, nCompared = 0, w;
    always #5 clk = ~clk;
    cmr_mode_ctrl dut (.clk, .rst, .reset_in_n(resN), .abort_in_n(abtN), .nonmaskable_irq_n(nmiN),
        .maskable_irq_n(irqN), .readyIn, .swBreakStart, .trapStart, .intReturnStep, .rmwModifyDone, .haltUntilIrqOp,
        .stopClockOp, .clearFlagsOp, .setFlagsOp, .pullFlagsOp, .flagsOperand, .exchangeEmu, .newEmulation,
        .setIrqDisable, .clrIrqDisable, .addrReq, .addrMode, .baseAddr, .addrOffset, .directReg, .isWrite, .isStore,
        .isRmw, .isLongStackOp, .emulationOut, .width_status_out, .widthValid, .decimalOut, .program_bank_reg,
        .data_bank_reg, .stackHighOut, .xHighOut, .yHighOut, .pushProgramBank, .effAddrOut, .valid_data_addr,
        .valid_program_addr, .fixCycleOut, .ready_line, .dataBusTransfer, .bankMuxEnable, .phase_two_clock_gate,
        .vectorTaken, .vectorSource, .resumeAfterWait, .abortPending, .interruptActive);
    cmr_mem_model mem (.clk, .rst, .stallReq, .valid_data_addr, .valid_program_addr, .bankMuxEnable, .effAddrOut,
        .readyIn, .lastAddr(), .bankLatch());
    task automatic finishTest;
        if (errTotal == 0 && nCompared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finishTest
    task automatic addrCase(input logic [2:0] m, input logic [15:0] b, o, d, input logic [23:0] e);
        addrMode <= m;
        baseAddr <= b;
        addrOffset <= o;
        directReg <= d;
        `PULSE(addrReq)
        `CHK("effAddr", e, effAddrOut)
        `CHK("validData", !(m == 3'h4 && (isStore | isRmw)), valid_data_addr)
    endtask : addrCase
    task automatic scAddr;
        `CHK("emu", 1'b1, emulationOut)
        addrCase(3'h0, 16'h01fe, 16'h0002, 16'h0000, 24'h000100);
        isLongStackOp <= 1'b1;
        addrCase(3'h1, 16'h01ff, 16'h0001, 16'h0000, 24'h000200);
        isLongStackOp <= 1'b0;
        addrCase(3'h2, 16'h00fe, 16'h0003, 16'h0000, 24'h000001);
        addrCase(3'h3, 16'h00fe, 16'h0002, 16'h0000, 24'h000100);
        addrCase(3'h2, 16'h00ff, 16'h0002, 16'h1200, 24'h001201);
        addrCase(3'h3, 16'h00ff, 16'h0001, 16'h1200, 24'h001300);
        addrCase(3'h2, 16'h00f0, 16'h0020, 16'h0012, 24'h000122);
        addrCase(3'h5, 16'h1234, 16'h0000, 16'h0000, 24'h001234);
        addrCase(3'h6, 16'h1234, 16'h0000, 16'h0000, 24'h001234);
        isRmw <= 1'b1;
        addrCase(3'h4, 16'hfff0, 16'h0020, 16'h0000, 24'h010010);
        `CHK("fixRmw", 1'b1, fixCycleOut)
        isRmw <= 1'b0;
    endtask : scAddr
    task automatic scFlags;
        flagsOperand <= 8'h30;
        `PULSE(clearFlagsOp)
        `CHK("widthEmu", 2'b11, width_status_out)
        newEmulation <= 1'b0;
        `PULSE(exchangeEmu)
        `CHK("native", 1'b0, emulationOut)
        `PULSE(clearFlagsOp)
        `CHK("widthValid", 1'b0, widthValid)
        repeat (2) @(posedge clk);
        #1;
        `CHK("widthNat", 2'b00, width_status_out)
        `PULSE(pullFlagsOp)
        `CHK("widthValidPull", 1'b0, widthValid)
        isStore <= 1'b1;
        addrCase(3'h4, 16'hffff, 16'h0001, 16'h0000, 24'h010000);
        `CHK("fixStore", 1'b1, fixCycleOut)
        isStore <= 1'b0;
        addrCase(3'h2, 16'h00ff, 16'h0002, 16'h1200, 24'h001301);
        newEmulation <= 1'b1;
        `PULSE(exchangeEmu)
        `CHK("widthSwitch", 2'b11, width_status_out)
        `CHK("stackSwitch", 8'h01, stackHighOut)
        `CHK("xSwitch", 8'h00, xHighOut)
        `CHK("ySwitch", 8'h00, yHighOut)
    endtask : scFlags
    task automatic intCase(input logic software_break_op, input logic pushExp);
        logic pushSeen;
        pushSeen = 1'b0;
        flagsOperand <= 8'h08;
        `PULSE(setFlagsOp)
        `CHK("decimalSet", 1'b1, decimalOut)
        swBreakStart <= software_break_op;
        trapStart <= !software_break_op;
        @(posedge clk);
        swBreakStart <= 1'b0;
        trapStart <= 1'b0;
        for (w = 0; w < 40 && vectorTaken !== 1'b1; w++) begin
            @(posedge clk);
            #1;
            pushSeen |= (pushProgramBank === 1'b1);
        end
        `TMO(vectorTaken === 1'b1)
        `CHK("decimalClr", 1'b0, decimalOut)
        `CHK("progBank", 8'h00, program_bank_reg)
        `CHK("dataBank", 8'h00, data_bank_reg)
        `CHK("pushBank", pushExp, pushSeen)
    endtask : intCase
    task automatic scInterrupt;
        intCase(1'b0, 1'b0);
        newEmulation <= 1'b0;
        `PULSE(exchangeEmu)
        intCase(1'b1, 1'b1);
    endtask : scInterrupt
    task automatic scWait;
        `PULSE(setIrqDisable)
        `PULSE(haltUntilIrqOp)
        `CHK("waitReady", 1'b0, ready_line)
        irqN <= 1'b0;
        `WAITFOR(resumeAfterWait === 1'b1)
        `CHK("noVector", 1'b0, vectorTaken)
        irqN <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK("resumeReady", 1'b1, ready_line)
        `PULSE(haltUntilIrqOp)
        nmiN <= 1'b0;
        `WAITFOR(vectorTaken === 1'b1)
        `CHK("nmiSource", 2'h2, vectorSource)
        nmiN <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : scWait
    task automatic scPriority;
        `PULSE(clrIrqDisable)
        abtN <= 1'b0;
        nmiN <= 1'b0;
        irqN <= 1'b0;
        // abort held two clocks, one synced cycle
        repeat (2) @(posedge clk);
        abtN <= 1'b1;
        `WAITFOR(vectorTaken === 1'b1)
        `CHK("prioSource", 2'h1, vectorSource)
        `CHK("abortLatch", 1'b0, abortPending)
        nmiN <= 1'b1;
        irqN <= 1'b1;
        repeat (40) @(posedge clk);
    endtask : scPriority
    task automatic scStop;
        logic g;
        isWrite <= 1'b1;
        `PULSE(stallReq)
        `CHK("stallTransfer", 1'b1, dataBusTransfer)
        isWrite <= 1'b0;
        repeat (5) @(posedge clk);
        `PULSE(stopClockOp)
        g = phase_two_clock_gate;
        `CHK("stopBankMux", 1'b0, bankMuxEnable)
        `CHK("stopTransfer", 1'b1, dataBusTransfer)
        resN <= 1'b0;
        `WAITFOR(phase_two_clock_gate !== g)
        `CHK("restart", !g, phase_two_clock_gate)
        resN <= 1'b1;
        repeat (20) @(posedge clk);
    endtask : scStop
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        scAddr();
        scFlags();
        scInterrupt();
        scWait();
        scPriority();
        scStop();
        finishTest();
    end
endmodule : test_cmr_mode_ctrl
`default_nettype wire
